// ### verilog/cpu_programming_model.sv
/*
 programming-model registers of an 8-bit cpu core with stack sequencer.
 assumes a sequencer issuing ops on opSel and a zero-wait memory whose
 read data is valid in the same cycle as memRead.
*/
module cpu_programming_model (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  opValid,
    input  wire cpu_model_pkg::op_t    opSel,
    input  wire logic [15:0]           opData,
    input  wire logic [15:0]           opTarget,
    input  wire logic                  opNmi,
    input  wire logic                  opUseY,
    input  wire cpu_model_pkg::cause_t resetCause,
    input  wire logic                  testMode,
    input  wire logic [7:0]            memRData,
    output logic                       opReady,
    output logic [15:0]                memAddr,
    output logic [7:0]                 memWData,
    output logic                       memWrite,
    output logic                       memRead,
    output logic [7:0]                 accA,
    output logic [7:0]                 accB,
    output logic [15:0]                accD,
    output logic [15:0]                indexRegX,
    output logic [15:0]                indexRegY,
    output logic [15:0]                stackPointer,
    output logic [15:0]                programCounter,
    output logic [7:0]                 conditionFlags,
    output logic [15:0]                effAddr,
    output logic                       extraCost,
    output logic [1:0]                 opcodePage,
    output logic                       stopEnter
);
    import cpu_model_pkg::*;

    state_t      state_reg;
    logic [7:0]  a_reg, b_reg, f_reg;
    logic [15:0] x_reg, y_reg, sp_reg, pc_reg, tgt_reg, vec_reg, ea_reg;
    logic [3:0]  step_reg, len_reg;
    logic        intFrame_reg, nmi_reg, cost_reg, stop_reg;
    logic [1:0]  page_reg;
    logic [7:0]  aNext, bNext, fNext;
    logic [15:0] xNext, yNext;
    logic [7:0]  pushByte;

    wire         take = opValid && (state_reg == ST_IDLE);
    wire [3:0]   slot = (state_reg == ST_PULL) ? 4'(len_reg - 4'h1 - step_reg)
                                               : step_reg;
    wire         lastStep = (step_reg == 4'(len_reg - 4'h1));
    // special modes share one vector for every cause
    wire [15:0]  resetVec = testMode ? VEC_SPECIAL
                          : (resetCause == CAUSE_CLOCK) ? VEC_CLOCK_MON
                          : (resetCause == CAUSE_WATCHDOG) ? VEC_WATCHDOG
                          : VEC_POWER;
    wire [7:0]   addend = (opSel == OP_SUM_B_INTO_A) ? b_reg : opData[7:0];
    wire         cin = (opSel == OP_ADD_CARRY_A) & f_reg[FLAG_C];
    wire [8:0]   sumWide = {1'b0, a_reg} + {1'b0, addend} + {8'h00, cin};
    wire [4:0]   halfWide = {1'b0, a_reg[3:0]} + {1'b0, addend[3:0]}
                          + {4'h0, cin};
    wire [8:0]   diffWide = {1'b0, a_reg} - {1'b0, b_reg};
    wire         lowFix = f_reg[FLAG_H] | (a_reg[3:0] > 4'h9);
    wire         highFix = f_reg[FLAG_C] | (a_reg > 8'h99);
    wire [7:0]   bcdVal = a_reg + {highFix ? 4'h6 : 4'h0,
                                   lowFix ? 4'h6 : 4'h0};
    wire [15:0]  product = {8'h00, a_reg} * {8'h00, b_reg};
    wire [15:0]  bWide = {8'h00, b_reg};

    // ops that change nothing but the accumulators, index registers and flags
    always_comb begin
        aNext = a_reg;
        bNext = b_reg;
        xNext = x_reg;
        yNext = y_reg;
        fNext = f_reg;
        unique case (opSel)
            OP_LOAD_A, OP_LOAD_B: begin
                if (opSel == OP_LOAD_A) aNext = opData[7:0];
                else bNext = opData[7:0];
                fNext[FLAG_N] = opData[7];
                fNext[FLAG_Z] = (opData[7:0] == 8'h00);
                fNext[FLAG_V] = 1'b0;
            end
            OP_LOAD_D, OP_LOAD_X, OP_LOAD_Y: begin
                if (opSel == OP_LOAD_D) {aNext, bNext} = opData;
                else if (opSel == OP_LOAD_X) xNext = opData;
                else yNext = opData;
                fNext[FLAG_N] = opData[15];
                fNext[FLAG_Z] = (opData == 16'h0000);
                fNext[FLAG_V] = 1'b0;
            end
            OP_ADD_A, OP_ADD_CARRY_A, OP_SUM_B_INTO_A: begin
                aNext = sumWide[7:0];
                fNext[FLAG_H] = halfWide[4];
                fNext[FLAG_C] = sumWide[8];
                fNext[FLAG_V] = (a_reg[7] == addend[7])
                              && (sumWide[7] != a_reg[7]);
                fNext[FLAG_N] = sumWide[7];
                fNext[FLAG_Z] = (sumWide[7:0] == 8'h00);
            end
            OP_SUB_B_FROM_A, OP_COMPARE_A_B: begin
                // compare keeps a and only reports the subtraction
                if (opSel == OP_SUB_B_FROM_A) aNext = diffWide[7:0];
                fNext[FLAG_C] = diffWide[8];
                fNext[FLAG_V] = (a_reg[7] != b_reg[7])
                              && (diffWide[7] != a_reg[7]);
                fNext[FLAG_N] = diffWide[7];
                fNext[FLAG_Z] = (diffWide[7:0] == 8'h00);
            end
            // b only, unsigned, flags untouched
            OP_ADD_B_TO_X: xNext = x_reg + bWide;
            OP_ADD_B_TO_Y: yNext = y_reg + bWide;
            OP_INC_X, OP_DEC_X: begin
                xNext = (opSel == OP_INC_X) ? x_reg + 16'h0001
                                            : x_reg - 16'h0001;
                fNext[FLAG_Z] = (xNext == 16'h0000);
            end
            OP_INC_Y, OP_DEC_Y: begin
                yNext = (opSel == OP_INC_Y) ? y_reg + 16'h0001
                                            : y_reg - 16'h0001;
                fNext[FLAG_Z] = (yNext == 16'h0000);
            end
            OP_COPY_FLAGS_TO_A: aNext = f_reg;
            OP_COPY_A_TO_FLAGS: begin
                // software may clear the nonmaskable mask, never set it
                fNext = a_reg;
                fNext[FLAG_X] = f_reg[FLAG_X] & a_reg[FLAG_X];
            end
            OP_DECIMAL_ADJUST_A: begin
                aNext = bcdVal;
                fNext[FLAG_C] = highFix;
                fNext[FLAG_N] = bcdVal[7];
                fNext[FLAG_Z] = (bcdVal == 8'h00);
            end
            OP_ROTATE_LEFT_A: begin
                aNext = {a_reg[6:0], f_reg[FLAG_C]};
                fNext[FLAG_C] = a_reg[7];
                fNext[FLAG_N] = a_reg[6];
                fNext[FLAG_Z] = ({a_reg[6:0], f_reg[FLAG_C]} == 8'h00);
                fNext[FLAG_V] = a_reg[7] ^ a_reg[6];
            end
            OP_MULTIPLY: begin
                {aNext, bNext} = product;
                fNext[FLAG_C] = product[7];
            end
            OP_CLEAR_IMASK: fNext[FLAG_I] = 1'b0;
            default: ;
        endcase
    end

    // interrupt frame byte order, slot 0 leaves first
    always_comb begin
        unique case (slot)
            4'h0: pushByte = pc_reg[7:0];
            4'h1: pushByte = pc_reg[15:8];
            4'h2: pushByte = y_reg[7:0];
            4'h3: pushByte = y_reg[15:8];
            4'h4: pushByte = x_reg[7:0];
            4'h5: pushByte = x_reg[15:8];
            4'h6: pushByte = a_reg;
            4'h7: pushByte = b_reg;
            default: pushByte = f_reg;
        endcase
    end

    // push at sp, pull at sp+1 vectors read high byte first
    assign memWrite = (state_reg == ST_PUSH);
    assign memRead = (state_reg == ST_PULL) || (state_reg == ST_VECTOR);
    assign memWData = memWrite ? pushByte : 8'h00;
    assign memAddr = (state_reg == ST_PUSH) ? sp_reg
                   : (state_reg == ST_PULL) ? sp_reg + 16'h0001
                   : (state_reg == ST_VECTOR) ? vec_reg + {12'h000, step_reg}
                   : 16'h0000;
    assign opReady = (state_reg == ST_IDLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_START;
            step_reg <= 4'h0;
            len_reg <= CALL_FRAME;
            intFrame_reg <= 1'b0;
            nmi_reg <= 1'b0;
            vec_reg <= VEC_POWER;
            tgt_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_START: begin
                    vec_reg <= resetVec;
                    state_reg <= ST_VECTOR;
                end
                ST_IDLE: if (take) begin
                    step_reg <= 4'h0;
                    intFrame_reg <= (opSel == OP_INTERRUPT)
                                 || (opSel == OP_RETURN_INT);
                    len_reg <= ((opSel == OP_INTERRUPT)
                             || (opSel == OP_RETURN_INT)) ? INT_FRAME
                                                          : CALL_FRAME;
                    nmi_reg <= opNmi;
                    tgt_reg <= opTarget;
                    vec_reg <= opData;
                    if (opSel == OP_CALL || opSel == OP_INTERRUPT)
                        state_reg <= ST_PUSH;
                    else if (opSel == OP_RETURN_SUB || opSel == OP_RETURN_INT)
                        state_reg <= ST_PULL;
                end
                ST_PUSH, ST_PULL: begin
                    step_reg <= step_reg + 4'h1;
                    if (lastStep) begin
                        step_reg <= 4'h0;
                        state_reg <= (state_reg == ST_PUSH && intFrame_reg)
                                   ? ST_VECTOR : ST_IDLE;
                    end
                end
                ST_VECTOR: begin
                    step_reg <= step_reg + 4'h1;
                    if (step_reg == 4'h1) begin
                        step_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            a_reg <= 8'h00;
            b_reg <= 8'h00;
            x_reg <= 16'h0000;
            y_reg <= 16'h0000;
            sp_reg <= 16'h0000;
            pc_reg <= 16'h0000;
            f_reg <= FLAGS_RESET;
        end else if (take) begin
            a_reg <= aNext;
            b_reg <= bNext;
            x_reg <= xNext;
            y_reg <= yNext;
            f_reg <= fNext;
            if (opSel == OP_LOAD_SP) sp_reg <= opData;
            if (opSel == OP_LOAD_PC || opSel == OP_CALL) pc_reg <= opData;
        end else if (state_reg == ST_PUSH) begin
            sp_reg <= sp_reg - 16'h0001;
            if (lastStep && intFrame_reg) begin
                // masks set only once the frame is stacked
                f_reg[FLAG_I] <= 1'b1;
                if (nmi_reg) f_reg[FLAG_X] <= 1'b1;
            end
            if (lastStep && !intFrame_reg) pc_reg <= tgt_reg;
        end else if (state_reg == ST_PULL) begin
            sp_reg <= sp_reg + 16'h0001;
            unique case (slot)
                4'h0: pc_reg[7:0] <= memRData;
                4'h1: pc_reg[15:8] <= memRData;
                4'h2: y_reg[7:0] <= memRData;
                4'h3: y_reg[15:8] <= memRData;
                4'h4: x_reg[7:0] <= memRData;
                4'h5: x_reg[15:8] <= memRData;
                4'h6: a_reg <= memRData;
                4'h7: b_reg <= memRData;
                default: begin
                    // a pulled flags byte may only clear the x mask
                    f_reg <= memRData;
                    f_reg[FLAG_X] <= f_reg[FLAG_X] & memRData[FLAG_X];
                end
            endcase
        end else if (state_reg == ST_VECTOR) begin
            if (step_reg == 4'h0) pc_reg[15:8] <= memRData;
            else pc_reg[7:0] <= memRData;
        end
    end

    // effective address, y cost and opcode page are sequencer hints
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ea_reg <= 16'h0000;
            cost_reg <= 1'b0;
            page_reg <= 2'h0;
            stop_reg <= 1'b0;
        end else begin
            stop_reg <= take && (opSel == OP_STOP) && !f_reg[FLAG_S];
            if (take && opSel == OP_INDEX_ADDR) begin
                ea_reg <= (opUseY ? y_reg : x_reg)
                        + {8'h00, opData[7:0]};
                cost_reg <= opUseY;
            end
            if (take) page_reg <= (opSel == OP_PREBYTE) ? opData[1:0]
                                                        : 2'h0;
        end
    end

    assign accA = a_reg;
    assign accB = b_reg;
    assign accD = {a_reg, b_reg};
    assign indexRegX = x_reg;
    assign indexRegY = y_reg;
    assign stackPointer = sp_reg;
    assign programCounter = pc_reg;
    assign conditionFlags = f_reg;
    assign effAddr = ea_reg;
    assign extraCost = cost_reg;
    assign opcodePage = page_reg;
    assign stopEnter = stop_reg;

    property p_push_dec;
        @(posedge clock) disable iff (rst)
        memWrite |=> stackPointer == $past(stackPointer) - 16'h0001;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push sp");
    property p_pull_addr;
        @(posedge clock) disable iff (rst)
        state_reg == ST_PULL |-> memAddr == stackPointer + 16'h0001;
    endproperty
    a_pull_addr: assert property (p_pull_addr) else $error("pull");
    property p_call_order;
        @(posedge clock) disable iff (rst)
        take && opSel == OP_CALL |=> memWData == $past(opData[7:0])
            ##1 memWData == $past(opData[15:8], 2);
    endproperty
    a_call_order: assert property (p_call_order) else $error("call");
    property p_xfer_flags;
        @(posedge clock) disable iff (rst)
        take && (opSel == OP_ADD_B_TO_X || opSel == OP_LOAD_SP)
            |=> $stable(conditionFlags);
    endproperty
    a_xfer_flags: assert property (p_xfer_flags) else $error("flag");
    property p_inc_zero;
        @(posedge clock) disable iff (rst)
        take && opSel == OP_INC_X |=> conditionFlags[2] ==
            (indexRegX == 16'h0000) && conditionFlags[7:3] ==
            $past(conditionFlags[7:3]);
    endproperty
    a_inc_zero: assert property (p_inc_zero) else $error("inc x");
    property p_int_mask;
        @(posedge clock) disable iff (rst)
        memWrite && intFrame_reg && lastStep |=> conditionFlags[4]
            && state_reg == ST_VECTOR ##2 state_reg == ST_IDLE;
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("int mask");
    property p_x_rise;
        @(posedge clock) disable iff (rst)
        $rose(conditionFlags[6]) |-> $past(memWrite && nmi_reg);
    endproperty
    a_x_rise: assert property (p_x_rise) else $error("x set");
    property p_stop_nop;
        @(posedge clock) disable iff (rst)
        take && opSel == OP_STOP |=> stopEnter == !$past(conditionFlags[7]);
    endproperty
    a_stop_nop: assert property (p_stop_nop) else $error("stop");
    property p_vec_order;
        @(posedge clock) disable iff (rst)
        state_reg == ST_START |=> memAddr == resetVec && memRead
            ##1 memAddr == $past(resetVec, 2) + 16'h0001;
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("vector");
    c_rti: cover property (@(posedge clock) take && opSel == OP_RETURN_INT);
    c_nmi: cover property (@(posedge clock) take && opSel == OP_INTERRUPT
        && opNmi);
    c_call: cover property (@(posedge clock) take && opSel == OP_CALL);
endmodule

// ### verilog/cpu_model_pkg.sv
/*
 constants and types of the cpu programming-model block.
 assumes one clock and a zero-wait byte-wide memory bus.
*/
// Function
// - two 8-bit accumulators pair as one 16-bit accumulator, a is high byte.
// - b-to-index add uses b only; decimal adjust and flag copies use a only.
// - indexed address is index register plus unsigned 8-bit offset.
// - second index register costs one more byte and one more cycle.
// - sp marks next free byte; push then decrement, increment then pull.
// - call pushes return address low byte first; return pulls it back.
// - interrupt pushes program counter, then all registers, then vectors; code pushes y, x, a, b and flags, not sp.
// - interrupt return pulls registers in reverse order, then resumes.
// - reset vector depends on cause in normal modes; special modes share one.
// - flag register holds five flags, two interrupt masks and stop disable.
// - stack, b-to-index add and transfers leave all flags unchanged.
// - carry marks carry or borrow, multiply result, and rotate pass-through.
// - overflow set on arithmetic overflow, cleared otherwise.
// - z set on zero result; compares subtract; index steps touch only z.
// - negative copies result msb.
// - maskable mask set by reset, cleared by software only.
// - any interrupt sets maskable mask after stacking, before vector fetch.
// - half carry is the carry from bit 3 into bit 4 on adds.
// - nonmaskable acknowledge sets both masks after stacking.
// - nonmaskable mask set by hardware only, cleared only by software loads.
// - stop disable turns stop into a no-operation; reset sets it.
// - words are big-endian byte pairs with no alignment rule.
// - 8-bit opcodes; a prebyte selects one of three extra pages.
package cpu_model_pkg;
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_I = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_X = 6;
    localparam int FLAG_S = 7;
    localparam logic [7:0]  FLAGS_RESET = 8'hD0;
    localparam logic [15:0] VEC_POWER = 16'hFFFE;
    localparam logic [15:0] VEC_CLOCK_MON = 16'hFFFC;
    localparam logic [15:0] VEC_WATCHDOG = 16'hFFFA;
    localparam logic [15:0] VEC_SPECIAL = 16'hBFFE;
    localparam logic [3:0]  CALL_FRAME = 4'h2;
    localparam logic [3:0]  INT_FRAME = 4'h9;
    typedef enum logic [1:0] {
        CAUSE_POWER = 2'h0, CAUSE_CLOCK = 2'h1, CAUSE_WATCHDOG = 2'h2
    } cause_t;
    typedef enum logic [4:0] {
        OP_LOAD_A = 5'h00, OP_LOAD_B = 5'h01, OP_LOAD_D = 5'h02,
        OP_LOAD_X = 5'h03, OP_LOAD_Y = 5'h04, OP_LOAD_SP = 5'h05,
        OP_LOAD_PC = 5'h06, OP_ADD_A = 5'h07, OP_ADD_CARRY_A = 5'h08,
        OP_SUM_B_INTO_A = 5'h09, OP_SUB_B_FROM_A = 5'h0A,
        OP_COMPARE_A_B = 5'h0B, OP_ADD_B_TO_X = 5'h0C,
        OP_ADD_B_TO_Y = 5'h0D, OP_INC_X = 5'h0E, OP_DEC_X = 5'h0F,
        OP_INC_Y = 5'h10, OP_DEC_Y = 5'h11, OP_COPY_FLAGS_TO_A = 5'h12,
        OP_COPY_A_TO_FLAGS = 5'h13, OP_DECIMAL_ADJUST_A = 5'h14,
        OP_ROTATE_LEFT_A = 5'h15, OP_MULTIPLY = 5'h16,
        OP_CLEAR_IMASK = 5'h17, OP_STOP = 5'h18, OP_INDEX_ADDR = 5'h19,
        OP_PREBYTE = 5'h1A, OP_CALL = 5'h1B, OP_RETURN_SUB = 5'h1C,
        OP_INTERRUPT = 5'h1D, OP_RETURN_INT = 5'h1E
    } op_t;
    typedef enum logic [4:0] {
        ST_START = 5'h01, ST_IDLE = 5'h02, ST_PUSH = 5'h04,
        ST_PULL = 5'h08, ST_VECTOR = 5'h10
    } state_t;
endpackage

// ### verification/mem_model.sv
/*
 zero-wait byte memory on the far side of the cpu bus.
 assumes one clock, reads combinational while memRead is high.
*/
module mem_model (
    input  wire logic        clock,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWData,
    input  wire logic        memWrite,
    input  wire logic        memRead,
    output logic [7:0]       memRData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:65535];
    logic [7:0] lastReg = 8'h00;
    // idle bus shows the inverse of the last byte so stale data never passes
    assign memRData = memRead ? mem[memAddr] : ~lastReg;
    always @(posedge clock) begin
        if (memWrite) mem[memAddr] <= memWData;
        if (memRead) lastReg <= mem[memAddr];
    end
endmodule

// ### verification/tb_top.sv
/*
 self-checking bench for the cpu programming-model block.
 assumes the memory model beside it and one 40 MHz clock.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cpu_model_pkg::*;
    typedef struct {
        op_t s;
        logic [7:0] a, b, r;
        logic [4:0] f;
        logic h;
    } row_t;
    logic        clock = 1'b0, rst = 1'b1, opValid = 1'b0;
    logic        opNmi = 1'b0, opUseY = 1'b0, testMode = 1'b0;
    op_t         opSel = OP_LOAD_A;
    cause_t      resetCause = CAUSE_POWER;
    logic [15:0] opData = 16'h0000, opTarget = 16'h0000;
    logic [7:0]  memRData, memWData, accA, accB, conditionFlags, f;
    logic [15:0] memAddr, accD, indexRegX, indexRegY, stackPointer;
    logic [15:0] programCounter, effAddr;
    logic        opReady, memWrite, memRead, extraCost, stopEnter;
    logic [1:0]  opcodePage;
    int          n_fail = 0, comparisons = 0, cycles = 0;
    logic [15:0] vb [4] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hBFFE};
    cause_t      cz [4] = '{CAUSE_POWER, CAUSE_CLOCK, CAUSE_WATCHDOG,
                            CAUSE_WATCHDOG};
    logic [7:0]  fr [9] = '{8'h45, 8'h23, 8'h44, 8'h33, 8'h22, 8'h11,
                            8'h55, 8'h66, 8'h00};
    // {h, n, z, v, c}; h is only judged on the add rows
    // rows lean on the carry and half carry left by the row above
    row_t rows [11] = '{
        '{OP_SUM_B_INTO_A, 8'h08, 8'h08, 8'h10, 5'b10000, 1'b1},
        '{OP_SUM_B_INTO_A, 8'h7F, 8'h01, 8'h80, 5'b11010, 1'b1},
        '{OP_SUM_B_INTO_A, 8'hFF, 8'h01, 8'h00, 5'b10101, 1'b1},
        '{OP_ADD_CARRY_A, 8'h0E, 8'h01, 8'h10, 5'b10000, 1'b1},
        '{OP_ROTATE_LEFT_A, 8'h80, 8'h01, 8'h00, 5'b00111, 1'b0},
        '{OP_ADD_A, 8'h09, 8'h08, 8'h11, 5'b10000, 1'b1},
        '{OP_DECIMAL_ADJUST_A, 8'h11, 8'h00, 8'h17, 5'b00000, 1'b0},
        '{OP_SUB_B_FROM_A, 8'h00, 8'h01, 8'hFF, 5'b01001, 1'b0},
        '{OP_SUB_B_FROM_A, 8'h80, 8'h01, 8'h7F, 5'b00010, 1'b0},
        '{OP_COMPARE_A_B, 8'h05, 8'h05, 8'h05, 5'b00100, 1'b0},
        '{OP_COMPARE_A_B, 8'h03, 8'h05, 8'h03, 5'b01001, 1'b0}};
    cpu_programming_model dut_u (.clock, .rst, .opValid, .opSel, .opData,
        .opTarget, .opNmi, .opUseY, .resetCause, .testMode, .memRData,
        .opReady, .memAddr, .memWData, .memWrite, .memRead, .accA, .accB,
        .accD, .indexRegX, .indexRegY, .stackPointer, .programCounter,
        .conditionFlags, .effAddr, .extraCost, .opcodePage, .stopEnter);
    mem_model mem_u (.clock, .memAddr, .memWData, .memWrite, .memRead,
        .memRData);
    always #12.5 clock = ~clock;
    task automatic final_report;
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // k keeps the request up so the next op follows back to back
    task automatic op(input op_t s, input logic [15:0] d, input logic k);
        int n = 0;
        opValid = 1'b1;
        opSel = s;
        opData = d;
        @(negedge clock);
        if (!k) begin
            opValid = 1'b0;
            do begin
                @(negedge clock);
                n++;
            end while (opReady !== 1'b1 && n < 40);
        end
    endtask
    task automatic do_reset(input cause_t c, input logic t);
        rst = 1'b1;
        resetCause = c;
        testMode = t;
        repeat (6) @(negedge clock);
        chk(16'(conditionFlags), 16'h00D0);
        chk(16'(opReady), 16'h0000);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk(16'(opReady), 16'h0001);
    endtask
    initial begin
        mem_u.mem[16'hFFF4] = 8'hAB;
        mem_u.mem[16'hFFF5] = 8'hCD;
        for (int i = 0; i < 4; i++) begin
            mem_u.mem[vb[i]] = 8'hA0 + 8'(i);
            mem_u.mem[vb[i] + 16'h0001] = 8'h5A;
        end
        for (int i = 0; i < 4; i++) begin
            do_reset(cz[i], i == 3);
            chk(programCounter, {8'hA0 + 8'(i), 8'h5A});
        end
        foreach (rows[i]) begin
            op(OP_LOAD_A, 16'(rows[i].a), 1'b1);
            op(OP_LOAD_B, 16'(rows[i].b), 1'b1);
            op(rows[i].s, 16'(rows[i].b), 1'b0);
            f = 8'(rows[i].f);
            chk(16'(accA), 16'(rows[i].r));
            chk(accD, {rows[i].r, rows[i].b});
            chk(16'(conditionFlags[1:0]), 16'(f[1:0]));
            chk(16'(conditionFlags[3:2]), 16'(f[3:2]));
            if (rows[i].h) chk(16'(conditionFlags[5]), 16'(f[4]));
        end
        op(OP_LOAD_A, 16'h000C, 1'b1);
        op(OP_LOAD_B, 16'h000C, 1'b1);
        op(OP_MULTIPLY, 16'h0000, 1'b0);
        chk(accD, 16'h0090);
        chk(16'(conditionFlags[0]), 16'h0001);
        op(OP_STOP, 16'h0000, 1'b1);
        chk(16'(stopEnter), 16'h0000);
        op(OP_LOAD_A, 16'h0000, 1'b1);
        op(OP_COPY_A_TO_FLAGS, 16'h0000, 1'b1);
        op(OP_STOP, 16'h0000, 1'b1);
        chk(16'(stopEnter), 16'h0001);
        chk(16'(conditionFlags), 16'h0000);
        op(OP_LOAD_A, 16'h00FF, 1'b1);
        op(OP_COPY_A_TO_FLAGS, 16'h0000, 1'b1);
        op(OP_COPY_FLAGS_TO_A, 16'h0000, 1'b0);
        chk(16'(accA), 16'h00BF);
        op(OP_LOAD_X, 16'hFFF0, 1'b1);
        op(OP_INDEX_ADDR, 16'h00F0, 1'b0);
        chk(effAddr, 16'h00E0);
        chk(16'(extraCost), 16'h0000);
        opUseY = 1'b1;
        op(OP_LOAD_Y, 16'h1000, 1'b1);
        op(OP_INDEX_ADDR, 16'h0080, 1'b0);
        chk(effAddr, 16'h1080);
        chk(16'(extraCost), 16'h0001);
        opUseY = 1'b0;
        op(OP_LOAD_X, 16'hFFFF, 1'b1);
        op(OP_LOAD_B, 16'h0020, 1'b0);
        f = conditionFlags;
        op(OP_INC_X, 16'h0000, 1'b0);
        chk(indexRegX, 16'h0000);
        chk(16'(conditionFlags), 16'(f | 8'h04));
        op(OP_ADD_B_TO_X, 16'h0000, 1'b1);
        op(OP_ADD_B_TO_Y, 16'h0000, 1'b0);
        chk(indexRegX, 16'h0020);
        chk(indexRegY, 16'h1020);
        chk(16'(conditionFlags), 16'(f | 8'h04));
        op(OP_PREBYTE, 16'h0002, 1'b1);
        chk(16'(opcodePage), 16'h0002);
        op(OP_LOAD_PC, 16'h2345, 1'b0);
        chk(16'(opcodePage), 16'h0000);
        op(OP_CLEAR_IMASK, 16'h0000, 1'b1);
        op(OP_LOAD_SP, 16'h0100, 1'b1);
        op(OP_LOAD_X, 16'h1122, 1'b1);
        op(OP_LOAD_Y, 16'h3344, 1'b1);
        op(OP_LOAD_A, 16'h0055, 1'b1);
        op(OP_LOAD_B, 16'h0066, 1'b0);
        f = conditionFlags;
        opTarget = 16'h4000;
        op(OP_CALL, 16'h2345, 1'b0);
        chk(16'(mem_u.mem[16'h0100]), 16'h0045);
        chk(16'(mem_u.mem[16'h00FF]), 16'h0023);
        chk(stackPointer, 16'h00FE);
        chk(programCounter, 16'h4000);
        op(OP_RETURN_SUB, 16'h0000, 1'b0);
        chk(programCounter, 16'h2345);
        chk(stackPointer, 16'h0100);
        chk(16'(conditionFlags), 16'(f));
        opNmi = 1'b1;
        op(OP_INTERRUPT, 16'hFFF4, 1'b0);
        opNmi = 1'b0;
        fr[8] = f;
        for (int i = 0; i < 9; i++)
            chk(16'(mem_u.mem[16'h0100 - 16'(i)]), 16'(fr[i]));
        chk(stackPointer, 16'h00F7);
        chk(programCounter, 16'hABCD);
        chk(16'(conditionFlags), 16'(f | 8'h50));
        op(OP_LOAD_A, 16'h0000, 1'b0);
        op(OP_RETURN_INT, 16'h0000, 1'b0);
        chk({accA, accB}, 16'h5566);
        chk(indexRegX, 16'h1122);
        chk(indexRegY, 16'h3344);
        chk(programCounter, 16'h2345);
        chk(stackPointer, 16'h0100);
        chk(16'(conditionFlags), 16'(f));
        final_report();
    end
endmodule
